// ===== common/agctc_cfg.svh
// Offsets, field positions, reset values and time figures of the AGC time-constant registers.
// Assumes inclusion by bare name from the package and the design file.
`ifndef AGCTC_CFG_SVH
`define AGCTC_CFG_SVH
`define AGCTC_OFS_LDECAY     8'h68
`define AGCTC_OFS_RATTACK    8'h69
`define AGCTC_RST_VAL        8'h00
`define AGCTC_SEL_BIT        7
`define AGCTC_BASE_HI        6
`define AGCTC_BASE_LO        5
`define AGCTC_MULT_HI        4
`define AGCTC_MULT_LO        2
`define AGCTC_RSVD_MASK      8'h03
`define AGCTC_DEC_BASE0_MS   16'h0032
`define AGCTC_DEC_BASE1_MS   16'h0096
`define AGCTC_DEC_BASE2_MS   16'h00FA
`define AGCTC_DEC_BASE3_MS   16'h015E
`define AGCTC_ATK_BASE0_MS   16'h0007
`define AGCTC_ATK_BASE1_MS   16'h0008
`define AGCTC_ATK_BASE2_MS   16'h000A
`define AGCTC_ATK_BASE3_MS   16'h000B
// Decay caps in ms, indexed by divide-ratio code (ratio 1, 1.5 .. 6 in half steps)
`define AGCTC_CAP_R1_0       16'h0FA0
`define AGCTC_CAP_R1_5       16'h15E0
`define AGCTC_CAP_R2_0       16'h1F40
`define AGCTC_CAP_R2_5       16'h2580
`define AGCTC_CAP_R3_X       16'h2BC0
`define AGCTC_CAP_R4_X       16'h3E80
`define AGCTC_CAP_R5_0       16'h4B00
`define AGCTC_CAP_R5_X       16'h5780
`endif

// ===== common/agctc_pkg.sv
// Types for the AGC time-constant register bank.
// Assumes agctc_cfg.svh is on the include path.
`default_nettype none
`include "agctc_cfg.svh"
package agctc_pkg;
   typedef struct packed {
      logic       sel;
      logic [1:0] base;
      logic [2:0] mult;
      logic [1:0] rsvd;
   } agctc_reg_t;
   typedef struct packed {
      logic        use_new;
      logic [15:0] time_ms;
   } agctc_time_t;
endpackage : agctc_pkg
`default_nettype wire

// ===== hdl/agctc_regs.sv
// Alternative AGC time-constant registers: left decay and right attack.
// Assumes a synchronous byte-wide register port from the control-bus decoder.
//
// Contract
// [R1] Left decay select clear uses old register 26, set uses new fields.
// [R2] Left decay baseline codes give 50, 150, 250, 350 ms.
// [R3] Decay multiplier is two to the field value, 1 to 128.
// [R4] Effective left decay is capped by the codec divide ratio.
// [R5] Right attack select clear uses old register 29, set uses new fields.
// [R6] Right attack baseline codes give 7, 8, 10, 11 ms.
// [R7] Attack multiplier is two to the field value, 1 to 128.
// [R8] Software writes zeros to reserved bits 1 to 0.
// [R9] Both registers read zero after reset.
// [R10] Fields stay stored and readable while select is clear.

`timescale 1ns/1ps
`default_nettype none
`include "agctc_cfg.svh"
module agctc_regs (
   input  wire logic        I_CLOCK,
   input  wire logic        I_RST,
   input  wire logic        i_ce,
   input  wire logic        i_wr,
   input  wire logic        i_rd,
   input  wire logic [7:0]  i_addr,
   input  wire logic [7:0]  i_wdata,
   input  wire logic [3:0]  i_codec_divide_ratio,
   output logic      [7:0]  o_rdata,
   output logic             o_rvalid,
   output var agctc_pkg::agctc_time_t o_left_decay,
   output var agctc_pkg::agctc_time_t o_right_attack
);
   agctc_pkg::agctc_reg_t ldecay;
   agctc_pkg::agctc_reg_t rattack;
   agctc_pkg::agctc_time_t next_left_decay;
   agctc_pkg::agctc_time_t next_right_attack;
   logic [7:0] next_rdata;

   // Baseline times, shared by both channels
   function automatic logic [15:0] agctc_base(input logic atk, input logic [1:0] code);
      logic [15:0] v;
      v = 16'h0000;
      case (code)
         2'b00:   v = atk ? `AGCTC_ATK_BASE0_MS : `AGCTC_DEC_BASE0_MS;
         2'b01:   v = atk ? `AGCTC_ATK_BASE1_MS : `AGCTC_DEC_BASE1_MS;
         2'b10:   v = atk ? `AGCTC_ATK_BASE2_MS : `AGCTC_DEC_BASE2_MS;
         default: v = atk ? `AGCTC_ATK_BASE3_MS : `AGCTC_DEC_BASE3_MS;
      endcase
      return v;
   endfunction : agctc_base

   // Ratio code is (ratio-1)*2, so 0 = 1, 10 = 6
   function automatic logic [15:0] agctc_cap(input logic [3:0] r);
      logic [15:0] c;
      c = `AGCTC_CAP_R5_X;
      case (r)
         4'h0:         c = `AGCTC_CAP_R1_0;
         4'h1:         c = `AGCTC_CAP_R1_5;
         4'h2:         c = `AGCTC_CAP_R2_0;
         4'h3:         c = `AGCTC_CAP_R2_5;
         4'h4, 4'h5:   c = `AGCTC_CAP_R3_X;
         4'h6, 4'h7:   c = `AGCTC_CAP_R4_X;
         4'h8:         c = `AGCTC_CAP_R5_0;
         default:      c = `AGCTC_CAP_R5_X;
      endcase
      return c;
   endfunction : agctc_cap

   // Worst case 350*128 = 44800 still fits 16 bits
   function automatic logic [15:0] agctc_scale(input logic [15:0] b, input logic [2:0] m);
      return 16'(b << m);
   endfunction : agctc_scale

   // [R9] Zero reset; [R8] reserved bits stored as written, software keeps them zero
   always_ff @(posedge I_CLOCK or posedge I_RST) begin
      if (I_RST) begin
         ldecay  <= agctc_pkg::agctc_reg_t'(`AGCTC_RST_VAL);
         rattack <= agctc_pkg::agctc_reg_t'(`AGCTC_RST_VAL);
      end else if (i_ce && i_wr) begin
         if (i_addr == `AGCTC_OFS_LDECAY) begin
            ldecay <= agctc_pkg::agctc_reg_t'(i_wdata);
         end
         if (i_addr == `AGCTC_OFS_RATTACK) begin
            rattack <= agctc_pkg::agctc_reg_t'(i_wdata);
         end
      end
   end

   // [R10] Readback independent of select
   always_comb begin
      next_rdata = 8'h00;
      if (i_addr == `AGCTC_OFS_LDECAY) begin
         next_rdata = ldecay;
      end else if (i_addr == `AGCTC_OFS_RATTACK) begin
         next_rdata = rattack;
      end
   end

   always_ff @(posedge I_CLOCK or posedge I_RST) begin
      if (I_RST) begin
         o_rdata  <= 8'h00;
         o_rvalid <= 1'b0;
      end else if (i_ce) begin
         o_rvalid <= i_rd;
         if (i_rd) begin
            o_rdata <= next_rdata;
         end
      end
   end

   always_comb begin
      logic [15:0] raw;
      raw = 16'h0000;
      // [R1] Select picks source; [R2] [R3] baseline times multiplier
      next_left_decay.use_new = ldecay.sel;
      raw = agctc_scale(agctc_base(1'b0, ldecay.base), ldecay.mult);
      // [R4] Cap by divide ratio
      if (raw > agctc_cap(i_codec_divide_ratio)) begin
         raw = agctc_cap(i_codec_divide_ratio);
      end
      // [R10] Fields ignored while select clear
      next_left_decay.time_ms = ldecay.sel ? raw : 16'h0000;
      // [R5] Select; [R6] [R7] baseline times multiplier
      next_right_attack.use_new = rattack.sel;
      next_right_attack.time_ms = rattack.sel ?
         agctc_scale(agctc_base(1'b1, rattack.base), rattack.mult) : 16'h0000;
   end

   always_ff @(posedge I_CLOCK or posedge I_RST) begin
      if (I_RST) begin
         o_left_decay   <= '0;
         o_right_attack <= '0;
      end else if (i_ce) begin
         o_left_decay   <= next_left_decay;
         o_right_attack <= next_right_attack;
      end
   end

   // Consequents look one edge on, at outputs launched from the cycle before;
   // inputs that feed them are therefore taken from the antecedent's cycle.

   // [R1] Old source when clear
   AST_LDEC_SEL: assert property (@(posedge I_CLOCK) disable iff (I_RST) // [R1]
      (i_ce && !ldecay.sel)
      |=> (!o_left_decay.use_new && o_left_decay.time_ms == 16'h0000))
      else $error("left decay used new fields while select clear");

   // [R1] New fields when set
   AST_LDEC_USE: assert property (@(posedge I_CLOCK) disable iff (I_RST) // [R1]
      (i_ce && ldecay.sel) |=> o_left_decay.use_new)
      else $error("left decay select not followed");

   // [R4] Cap never exceeded
   AST_LDEC_CAP: assert property (@(posedge I_CLOCK) disable iff (I_RST) // [R4]
      i_ce |=> (o_left_decay.time_ms <= agctc_cap($past(i_codec_divide_ratio))))
      else $error("left decay exceeds divide-ratio cap");

   // [R4] Longest setting clipped at ratio 1
   AST_LDEC_CAP_LO: assert property (@(posedge I_CLOCK) disable iff (I_RST) // [R4]
      (i_ce && ldecay == 8'hFC && i_codec_divide_ratio == 4'h0)
      |=> (o_left_decay.time_ms == 16'h0FA0))
      else $error("left decay not clipped to 4 s");

   // [R4] Longest setting clipped at ratio 6
   AST_LDEC_CAP_HI: assert property (@(posedge I_CLOCK) disable iff (I_RST) // [R4]
      (i_ce && ldecay == 8'hFC && i_codec_divide_ratio == 4'hA)
      |=> (o_left_decay.time_ms == 16'h5780))
      else $error("left decay not clipped to 22.4 s");

   // [R2] Smallest setting gives 50 ms
   AST_LDEC_BASE: assert property (@(posedge I_CLOCK) disable iff (I_RST) // [R2]
      (i_ce && ldecay == 8'h80) |=> (o_left_decay.time_ms == 16'h0032))
      else $error("left decay baseline wrong");

   // [R2] Top baseline unscaled
   AST_LDEC_BASE3: assert property (@(posedge I_CLOCK) disable iff (I_RST) // [R2]
      (i_ce && ldecay == 8'hE0) |=> (o_left_decay.time_ms == 16'h015E))
      else $error("left decay top baseline wrong");

   // [R3] 150 ms times 8, under every cap
   AST_LDEC_MULT: assert property (@(posedge I_CLOCK) disable iff (I_RST) // [R3]
      (i_ce && ldecay == 8'hAC) |=> (o_left_decay.time_ms == 16'h04B0))
      else $error("left decay multiplier wrong");

   // [R5] Old source when clear
   AST_RATK_CLR: assert property (@(posedge I_CLOCK) disable iff (I_RST) // [R5]
      (i_ce && !rattack.sel)
      |=> (!o_right_attack.use_new && o_right_attack.time_ms == 16'h0000))
      else $error("right attack used new fields while select clear");

   // [R5] New fields when set
   AST_RATK_SEL: assert property (@(posedge I_CLOCK) disable iff (I_RST) // [R5]
      (i_ce && rattack.sel) |=> o_right_attack.use_new)
      else $error("right attack select not followed");

   // [R6] Top baseline unscaled
   AST_RATK_BASE: assert property (@(posedge I_CLOCK) disable iff (I_RST) // [R6]
      (i_ce && rattack == 8'hE0) |=> (o_right_attack.time_ms == 16'h000B))
      else $error("right attack baseline wrong");

   // [R7] 10 ms times 128
   AST_RATK_MULT: assert property (@(posedge I_CLOCK) disable iff (I_RST) // [R7]
      (i_ce && rattack == 8'hDC) |=> (o_right_attack.time_ms == 16'h0500))
      else $error("right attack multiplier wrong");

   // [R7] Top factor on top baseline
   AST_RATK_MAX: assert property (@(posedge I_CLOCK) disable iff (I_RST) // [R7]
      (i_ce && rattack == 8'hFC) |=> (o_right_attack.time_ms == 16'h0580))
      else $error("right attack top setting wrong");

   // [R9] All zero as reset lifts
   AST_RST_ZERO: assert property (@(posedge I_CLOCK) // [R9]
      $fell(I_RST) |-> (ldecay == 8'h00 && rattack == 8'h00 && o_left_decay == '0 &&
                        o_right_attack == '0 && o_rdata == 8'h00 && !o_rvalid))
      else $error("registers not zero after reset");

   // [R10] Fields kept while select clear
   AST_READBACK: assert property (@(posedge I_CLOCK) disable iff (I_RST) // [R10]
      (i_ce && i_wr && i_addr == `AGCTC_OFS_LDECAY && !i_wdata[7])
      ##1 (i_ce && !i_wr)
      ##1 (i_ce && i_rd && !i_wr && i_addr == `AGCTC_OFS_LDECAY)
      |=> (o_rvalid && o_rdata == $past(i_wdata, 3)))
      else $error("stored fields not read back");

   // [R10] Both registers, left decay output and read data hold while enable low
   AST_FREEZE: assert property (@(posedge I_CLOCK) disable iff (I_RST) // [R10]
      !i_ce |=> ($stable(ldecay) && $stable(rattack) && $stable(o_left_decay) &&
                 $stable(o_rdata)))
      else $error("state moved while clock enable low");

   // [R10] One valid pulse per read
   AST_RVALID: assert property (@(posedge I_CLOCK) disable iff (I_RST) // [R10]
      i_ce |=> (o_rvalid == $past(i_rd)))
      else $error("read valid does not follow read strobe");
endmodule : agctc_regs
`default_nettype wire

// ===== test/agctc_regs_tb.sv
// Self-checking bench for the AGC time-constant register bank.
// Assumes agctc_pkg is compiled first; drives the register port directly.
`timescale 1ns/1ps
`default_nettype none
module agctc_regs_tb;
   logic                   clk, rst, ce, wr, rd;
   logic [7:0]             addr, wdata, rdata, vd, va;
   logic [3:0]             ratio;
   logic                   rvalid;
   agctc_pkg::agctc_time_t ldec, ratk;
   integer                 seed, err_count, num_checks, k;

   agctc_regs DUT (.I_CLOCK(clk), .I_RST(rst), .i_ce(ce), .i_wr(wr), .i_rd(rd),
      .i_addr(addr), .i_wdata(wdata), .i_codec_divide_ratio(ratio), .o_rdata(rdata),
      .o_rvalid(rvalid), .o_left_decay(ldec), .o_right_attack(ratk));

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   // Decay caps at the divide ratio; attack is never capped
   function automatic logic [16:0] exp_time(input logic [7:0] v, input logic dec,
                                            input logic [3:0] r);
      logic [15:0] t, cap;
      case (r)
         4'h0: cap = 16'h0FA0;
         4'h1: cap = 16'h15E0;
         4'h2: cap = 16'h1F40;
         4'h3: cap = 16'h2580;
         4'h4, 4'h5: cap = 16'h2BC0;
         4'h6, 4'h7: cap = 16'h3E80;
         4'h8: cap = 16'h4B00;
         default: cap = 16'h5780;
      endcase
      t = dec ? 16'h0032 + 16'h0064 * v[6:5] : 16'h0007 + v[6:5] + v[6];
      t = t << v[4:2];
      if (dec && t > cap) t = cap;
      return v[7] ? {1'b1, t} : 17'h00000;
   endfunction : exp_time

   task automatic close_out;
      $display("checks %0d, mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : close_out

   task automatic chk(input logic [16:0] seen, input logic [16:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      #1;
      wr    = 1'b1;
      addr  = a;
      wdata = d;
      @(posedge clk);
      #1;
      wr = 1'b0;
   endtask : wr_reg

   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
      integer n;
      @(posedge clk);
      #1;
      rd   = 1'b1;
      addr = a;
      @(posedge clk);
      #1;
      rd = 1'b0;
      for (n = 0; n < 4 && rvalid !== 1'b1; n++) begin
         @(posedge clk);
         #1;
      end
      if (rvalid !== 1'b1) begin
         err_count++;
         close_out();
      end else begin
         chk({9'h000, rdata}, {9'h000, e});
      end
   endtask : rd_chk

   // Program both registers, then compare outputs and read-back
   task automatic apply(input logic [3:0] r);
      ratio = r;
      wr_reg(8'h68, vd);
      wr_reg(8'h69, va);
      repeat (3) @(posedge clk);
      #1 chk(ldec, exp_time(vd, 1'b1, r));
      chk(ratk, exp_time(va, 1'b0, r));
      rd_chk(8'h68, vd);
      rd_chk(8'h69, va);
   endtask : apply

   initial begin
      seed = 32'h45422666;
      err_count = 0;
      num_checks = 0;
      {ce, wr, rd, addr, wdata, ratio, rst} = {3'h4, 8'h00, 8'h00, 4'h0, 1'b1};
      repeat (6) @(posedge clk);
      #1 rst = 1'b0;
      rd_chk(8'h68, 8'h00);
      rd_chk(8'h69, 8'h00);
      chk(ldec, 17'h00000);
      chk(ratk, 17'h00000);
      $display("reset test done");
      // Reserved bits kept zero; every code at both cap extremes
      for (k = 0; k < 64; k++) begin
         vd = {1'b1, k[4:0], 2'b00};
         va = {1'b1, k[4:0], 2'b00};
         apply(k[5] ? 4'hA : 4'h0);
      end
      $display("code table test done");
      for (k = 0; k < 40; k++) begin
         vd = 8'($random(seed)) & 8'hFC;
         va = 8'($random(seed)) & 8'hFC;
         apply(4'($random(seed)));
      end
      $display("random test done");
      wr_reg(8'h6A, 8'hFF);
      rd_chk(8'h6A, 8'h00);
      @(posedge clk);
      #1 ce = 1'b0;
      wr_reg(8'h68, 8'h7C);
      ce = 1'b1;
      rd_chk(8'h68, vd);
      // Write with select clear, read back right after
      wr_reg(8'h68, 8'h5C);
      rd_chk(8'h68, 8'h5C);
      chk(ldec, 17'h00000);
      $display("refusal test done");
      close_out();
   end
endmodule : agctc_regs_tb
`default_nettype wire
